// File: rtl/pbt_pkg.sv
package pbt_pkg;
    // Clock period in picoseconds (40 MHz)
    localparam int CLK_PS = 25000;
    // Protocol times in nanoseconds
    localparam int ARB_DELAY_NS = 2400;
    localparam int BUS_CLEAR_NS = 800;
    localparam int BUS_FREE_NS = 800;
    localparam int BUS_SET_NS = 1600;
    localparam int SETTLE_NS = 400;
    localparam int FREE_RELEASE_NS = 1200;
    localparam int DATA_RELEASE_NS = 400;
    localparam int QAS_ARB_NS = 1000;
    localparam int ATN_SETUP_NS = 90;
    localparam int FC_SETUP_NS = 49;
    localparam int FC_HOLD_NS = 39;
    localparam int PCRC_SETUP_NS = 49;
    localparam int PCRC_HOLD_NS = 39;
    // Long times in microseconds / milliseconds
    localparam int DISC_DELAY_US = 200;
    localparam int FILTER_MS = 100;
    // Minimum counts round up, maximum counts round down
    localparam int ARB_CYC = (ARB_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CLEAR_CYC = (BUS_CLEAR_NS * 1000) / CLK_PS;
    localparam int FREE_CYC = (BUS_FREE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SET_CYC = (BUS_SET_NS * 1000) / CLK_PS;
    localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int FREE_REL_CYC = (FREE_RELEASE_NS * 1000) / CLK_PS;
    localparam int DREL_CYC = (DATA_RELEASE_NS * 1000) / CLK_PS;
    localparam int QAS_CYC = (QAS_ARB_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int ATN_CYC = (ATN_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int FCS_CYC = (FC_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int FCH_CYC = (FC_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int PCS_CYC = (PCRC_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int PCH_CYC = (PCRC_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int DISC_CYC_DEF = (DISC_DELAY_US * 1000000) / CLK_PS;
    localparam int FILTER_CYC_DEF = 4000000;
    // Counter width
    localparam int CW = 24;
    // Register offsets
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_STAT = 4'h1;
    localparam logic [3:0] A_CMD = 4'h2;
    // Control field positions
    localparam int C_ARB_EN = 0;
    localparam int C_QAS_EN = 1;
    localparam int C_PCRC_EN = 2;
    localparam int C_MODE_LO = 3;
    localparam int C_MODE_HI = 4;
    localparam int C_TGT = 5;
    localparam int C_ID_LO = 8;
    localparam int C_ID_HI = 10;
    // Command bits
    localparam int K_ATN = 0;
    localparam int K_LAST = 1;
    localparam int K_DISC = 2;
    localparam int K_PCRCA = 3;
    localparam int K_LQ = 4;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    // Transfer modes
    localparam logic [1:0] M_DG = 2'h0;
    localparam logic [1:0] M_IU = 2'h1;
    localparam logic [1:0] M_PACED = 2'h2;
    // Arbiter states
    typedef enum logic [2:0] {
        S_IDLE, S_FREEWAIT, S_ARB, S_WON, S_LOST, S_DISC
    } pbt_state_t;
endpackage

// File: rtl/pbt_core.sv
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module pbt_core
    import pbt_pkg::*;
#(
    parameter int DISC_CYC = DISC_CYC_DEF,
    parameter int FILTER_CYC = FILTER_CYC_DEF
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [3:0] addr, // Register address
    input wire logic [15:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [15:0] rdata, // Read data, next cycle
    input wire logic bsy_in, // Bus BSY level
    input wire logic sel_in, // Bus SEL level
    input wire logic rst_in, // Bus RST level
    input wire logic msg_in, // Bus MSG level
    input wire logic cd_in, // Bus C/D level
    input wire logic io_in, // Bus I/O level
    input wire logic [7:0] db_in, // Data lines
    input wire logic ack_in, // ACK level
    input wire logic req_in, // REQ level (own, sampled)
    input wire logic mode_ok, // Mode-sense in valid range
    input wire logic phase_act, // Bus phase active
    input wire logic ready_in, // Core ready for commands
    output logic bsy_oe, // Drive BSY
    output logic [7:0] db_oe, // Drive data lines
    output logic atn_oe, // Drive ATN
    output logic pcrca_oe, // Drive P_CRCA
    output logic req_ok, // REQ may be issued
    output logic won, // Arbitration won pulse
    output logic mode_valid, // Bus mode accepted
    output logic ready_out // Target may answer commands
);
    // Registers
    logic [15:0] ctrl_reg, ctrl_next; // Control
    logic [4:0] cmd_reg; // Pending command bits
    pbt_state_t st_reg, st_next; // Arbiter state
    logic [CW-1:0] cnt_reg; // Phase timer
    logic [CW-1:0] free_reg; // Bus-false run length
    logic [CW-1:0] filt_reg; // Mode filter counter
    logic [CW-1:0] disc_reg; // Disconnect hold-off
    logic [7:0] atn_age_reg; // Cycles since ATN drive
    logic [7:0] pc_age_reg; // Cycles since P_CRCA change
    logic [7:0] req_age_reg; // Cycles since REQ edge
    logic req_d_reg; // REQ delayed
    logic io_d_reg; // I/O delayed
    logic [7:0] drel_reg; // Data release countdown
    logic [2:0] id_q; // Own ID

    // Decode helper
    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        return a == b;
    endfunction

    // Named decodes
    wire bus_false = !bsy_in && !sel_in;
    wire free_det = free_reg >= CW'(SETTLE_CYC);
    wire [1:0] mode = ctrl_reg[C_MODE_HI:C_MODE_LO];
    wire ctrl_wr = wr && hit(addr, A_CTRL) && !phase_act;
    wire lose = sel_in && (st_reg == S_ARB);
    wire qas_ok = ctrl_reg[C_QAS_EN] && !msg_in && !cd_in && !io_in;
    wire req_edge = req_in != req_d_reg;
    wire atn_ready = atn_age_reg >= 8'(ATN_CYC);
    wire pc_setup = pc_age_reg >= 8'(ctrl_reg[C_PCRC_EN] ? PCS_CYC : FCS_CYC);
    wire pc_hold = req_age_reg >= 8'(ctrl_reg[C_PCRC_EN] ? PCH_CYC : FCH_CYC);
    wire want_pc = cmd_reg[K_PCRCA] && cmd_reg[K_LAST] && !cmd_reg[K_LQ];
    wire pc_change = (want_pc != pcrca_oe) && pc_hold;
    // All modes gate the last word alike on ATN and LAST; ACK is not sampled
    wire gate_ack = (mode == M_PACED);
    wire last_gate = cmd_reg[K_ATN] && cmd_reg[K_LAST] && (gate_ack || mode != M_PACED);
    wire [7:0] id_bit = 8'h01 << id_q;

    // Next state of the arbiter
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            S_IDLE: begin
                if (free_det && ctrl_reg[C_ARB_EN] && disc_reg == '0) begin
                    st_next = S_FREEWAIT;
                end
            end
            S_FREEWAIT: begin
                if (!bus_false) begin
                    st_next = S_IDLE;
                end else if (cnt_reg >= CW'(FREE_CYC - 1)) begin
                    st_next = S_ARB;
                end
            end
            S_ARB: begin
                if (lose || rst_in) begin
                    st_next = S_LOST;
                end else if (cnt_reg >= CW'(ARB_CYC) || (qas_ok && cnt_reg >= CW'(QAS_CYC))) begin
                    st_next = (db_in & ~id_bit) < id_bit ? S_WON : S_LOST;
                end
            end
            S_WON: begin
                if (rst_in) begin
                    st_next = S_IDLE;
                end else if (cmd_reg[K_DISC]) begin
                    st_next = S_DISC;
                end
            end
            S_LOST: begin
                if (cnt_reg >= CW'(SETTLE_CYC)) begin
                    st_next = S_IDLE;
                end
            end
            S_DISC: st_next = S_IDLE;
            default: st_next = S_IDLE;
        endcase
        if (rst_in) begin
            st_next = S_IDLE;
        end
    end

    // Control register next value
    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr) begin
            ctrl_next = wdata;
        end
    end

    // Arbiter state and timers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= S_IDLE;
            cnt_reg <= '0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= (st_next != st_reg) ? '0 : cnt_reg + CW'(1);
        end
    end

    // Bus-false run length for free detection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            free_reg <= '0;
        end else if (!bus_false) begin
            free_reg <= '0;
        end else if (free_reg != {CW{1'b1}}) begin
            free_reg <= free_reg + CW'(1);
        end
    end

    // Disconnect hold-off timer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            disc_reg <= '0;
        end else if (st_reg == S_DISC) begin
            disc_reg <= CW'(DISC_CYC);
        end else if (disc_reg != '0) begin
            disc_reg <= disc_reg - CW'(1);
        end
    end

    // Mode-sense filter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            filt_reg <= '0;
            mode_valid <= 1'b0;
        end else begin
            filt_reg <= !mode_ok ? '0 : (mode_valid ? filt_reg : filt_reg + CW'(1));
            mode_valid <= mode_ok && filt_reg >= CW'(FILTER_CYC - 1);
        end
    end

    // Registers and command bits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= CTRL_RST;
            cmd_reg <= '0;
            id_q <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            id_q <= ctrl_reg[C_ID_HI:C_ID_LO];
            if (wr && hit(addr, A_CMD)) begin
                cmd_reg <= wdata[4:0];
            end else if (st_reg == S_DISC) begin
                cmd_reg[K_DISC] <= 1'b0;
            end
        end
    end

    // Setup and hold age counters
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            atn_age_reg <= '0;
            pc_age_reg <= '0;
            req_age_reg <= '0;
            req_d_reg <= 1'b0;
            io_d_reg <= 1'b0;
        end else begin
            req_d_reg <= req_in;
            io_d_reg <= io_in;
            atn_age_reg <= !atn_oe ? '0 : (atn_ready ? atn_age_reg : atn_age_reg + 8'h01);
            pc_age_reg <= pc_change ? '0 : (pc_age_reg == 8'hFF ? pc_age_reg : pc_age_reg + 8'h01);
            req_age_reg <= req_edge ? '0 : (req_age_reg == 8'hFF ? req_age_reg : req_age_reg + 8'h01);
        end
    end

    // Data release countdown after I/O rise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            drel_reg <= '0;
        end else if (io_in && !io_d_reg && !ctrl_reg[C_TGT]) begin
            drel_reg <= 8'(DREL_CYC);
        end else if (drel_reg != '0) begin
            drel_reg <= drel_reg - 8'h01;
        end
    end

    // Bus drive outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bsy_oe <= 1'b0;
            db_oe <= '0;
            atn_oe <= 1'b0;
            pcrca_oe <= 1'b0;
            req_ok <= 1'b0;
            won <= 1'b0;
            ready_out <= 1'b0;
        end else begin
            // Arbitration drives BSY, and ID too unless an initiator sees I/O true; releases in one cycle
            bsy_oe <= (st_next == S_ARB) || (st_next == S_WON);
            db_oe <= (st_next == S_ARB && !(io_in && !ctrl_reg[C_TGT])) ? id_bit : 8'h00;
            atn_oe <= cmd_reg[K_ATN] && st_next != S_IDLE;
            if (pc_change) begin
                pcrca_oe <= want_pc;
            end
            // REQ allowed once P_CRCA setup is met, and ATN setup too on the last word (ATN and LAST set)
            req_ok <= pc_setup && (!last_gate || atn_ready);
            won <= (st_next == S_WON) && (st_reg == S_ARB);
            ready_out <= ready_in;
        end
    end

    // Register read port
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (rd) begin
            rdata <= hit(addr, A_CTRL) ? ctrl_reg :
                     hit(addr, A_STAT) ? {9'h000, mode_valid, free_det, st_reg, ack_in, req_in} :
                     hit(addr, A_CMD) ? {11'h000, cmd_reg} : 16'h0000;
        end else begin
            rdata <= '0;
        end
    end

    // Checks

    // BSY dropped the cycle after RST
    chk_bsy_release: assert property (@(posedge clk) disable iff (!rst_b)
        rst_in |=> !bsy_oe) else $error("BSY held after RST");

    // BSY only after the free delay
    chk_free_wait: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(bsy_oe) |-> free_reg >= CW'(FREE_CYC)) else $error("BSY too early");

    // No win before the shortest sampling delay
    chk_arb_sample: assert property (@(posedge clk) disable iff (!rst_b)
        won |-> $past(cnt_reg) >= CW'(QAS_CYC)) else $error("early win");

    // Mode accepted only after a full filter run
    chk_mode_filt: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(mode_valid) |-> filt_reg >= CW'(FILTER_CYC - 1)) else $error("mode early");

    // Initiator lets go of the data lines on I/O
    chk_data_rel: assert property (@(posedge clk) disable iff (!rst_b)
        (io_in && !ctrl_reg[C_TGT]) |=> db_oe == 8'h00) else $error("data held");

    // No arbitration while the hold-off runs
    chk_disc_hold: assert property (@(posedge clk) disable iff (!rst_b)
        disc_reg != '0 |-> st_next != S_FREEWAIT || st_reg != S_IDLE) else $error("disc");

    // Losing to SEL keeps BSY released
    chk_lose_rel: assert property (@(posedge clk) disable iff (!rst_b)
        lose |=> !bsy_oe ##1 !bsy_oe) else $error("held after lose");

    // Free wait entered only on a settled bus
    chk_free_cnt: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg == S_FREEWAIT |-> free_reg >= CW'(SETTLE_CYC)) else $error("not free");

    // Plain arbitration waits the full delay
    chk_arb_wait: assert property (@(posedge clk) disable iff (!rst_b)
        won && !ctrl_reg[C_QAS_EN] |-> $past(cnt_reg) >= CW'(ARB_CYC)) else $error("short arb");

    // RST sends the arbiter home
    chk_rst_idle: assert property (@(posedge clk) disable iff (!rst_b)
        rst_in |=> st_reg == S_IDLE) else $error("state after RST");

    // SEL from a rival ends arbitration
    chk_lose_state: assert property (@(posedge clk) disable iff (!rst_b)
        lose && !rst_in |=> st_reg == S_LOST) else $error("no loss on SEL");

    // BSY not driven while idle or waiting for free
    chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (st_reg == S_IDLE || st_reg == S_FREEWAIT) |-> !bsy_oe) else $error("BSY idle");

    // BSY and own ID rise together
    chk_set_id: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg == S_FREEWAIT && st_next == S_ARB && !io_in |=> bsy_oe && db_oe == id_bit)
        else $error("BSY without ID");

    // Lost arbitration waits a settle delay
    chk_lost_settle: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg == S_LOST && st_next == S_IDLE && !rst_in |-> cnt_reg >= CW'(SETTLE_CYC))
        else $error("short settle");

    // REQ on the last word only after ATN setup
    chk_atn_gate: assert property (@(posedge clk) disable iff (!rst_b)
        req_ok && $past(last_gate) |-> $past(atn_ready)) else $error("ATN setup");

    // REQ only once P_CRCA setup is met
    chk_pc_req: assert property (@(posedge clk) disable iff (!rst_b)
        req_ok |-> $past(pc_setup)) else $error("P_CRCA setup");

    // P_CRCA moves only after REQ hold
    chk_pc_hold: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(pcrca_oe) |-> $past(pc_hold)) else $error("P_CRCA hold");

    // Data lines stay off during release countdown
    chk_drel: assert property (@(posedge clk) disable iff (!rst_b)
        drel_reg != '0 |-> db_oe == 8'h00) else $error("data in release");

    // Control frozen across an active phase
    chk_ctrl_frozen: assert property (@(posedge clk) disable iff (!rst_b)
        phase_act |=> ctrl_reg == $past(ctrl_reg)) else $error("ctrl moved");

    // Readiness follows the core a cycle later
    chk_ready: assert property (@(posedge clk) disable iff (!rst_b)
        ready_out == $past(ready_in)) else $error("ready lag");

    // Win is a single-cycle pulse
    chk_won_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        won |=> !won) else $error("won stuck");

    // Disconnect loads the full hold-off
    chk_disc_load: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg == S_DISC |=> disc_reg == CW'(DISC_CYC)) else $error("disc load");

    // Phase timer restarts on every state change
    chk_cnt_clear: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg != $past(st_reg) |-> cnt_reg == '0) else $error("timer kept");

    // Mode dropped as soon as sense leaves range
    chk_mode_drop: assert property (@(posedge clk) disable iff (!rst_b)
        !mode_ok |=> !mode_valid) else $error("mode kept");

    // Busy bus restarts the free run
    chk_free_reset: assert property (@(posedge clk) disable iff (!rst_b)
        !bus_false |=> free_reg == '0) else $error("free run kept");
endmodule

// File: testbench/pbt_bus_model.sv
`timescale 1ns/1ps
// Other devices on the bus, seen as wired-OR lines with false-level termination
module pbt_bus_model (
    input wire logic bsy_oe, // Own BSY drive
    input wire logic [7:0] db_oe, // Own data drive
    input wire logic o_bsy, // Another device drives BSY
    input wire logic o_sel, // Another device drives SEL
    input wire logic o_rst, // Another device drives RST
    input wire logic [2:0] o_phase, // MSG, C/D, I/O from a target
    input wire logic [7:0] o_db, // Rival ID bits
    output logic bsy_in, // BSY level
    output logic sel_in, // SEL level
    output logic rst_in, // RST level
    output logic msg_in, // MSG level
    output logic cd_in, // C/D level
    output logic io_in, // I/O level
    output logic [7:0] db_in // Data level
);
    // Released lines fall back to false through termination
    assign bsy_in = bsy_oe | o_bsy;
    assign sel_in = o_sel;
    assign rst_in = o_rst;
    assign {msg_in, cd_in, io_in} = o_phase;
    // Rival IDs merge with our own on the data lines
    assign db_in = db_oe | o_db;
endmodule

// File: testbench/test_pbt_core.sv
`timescale 1ns/1ps
module test_pbt_core;
    import pbt_pkg::*;
    typedef struct {logic [3:0] a; logic [15:0] d; logic w; logic [15:0] e;} pbt_row_t;
    logic clk = 1'b0; // System clock
    logic rst_b = 1'b0; // Reset, active low
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0;
    logic ack_in = 1'b0, req_in = 1'b0, mode_ok = 1'b0, phase_act = 1'b0, ready_in = 1'b0;
    logic o_bsy = 1'b1, o_sel = 1'b0, o_rst = 1'b0; // Far side drives
    logic [2:0] o_phase = 3'h0;
    logic [7:0] o_db = 8'h00;
    logic [15:0] rdata, v;
    logic bsy_in, sel_in, rst_in, msg_in, cd_in, io_in, bsy_oe, atn_oe, pcrca_oe;
    logic req_ok, won, mode_valid, ready_out;
    logic [7:0] db_in, db_oe;
    int n_fail = 0, checks = 0, cyc = 0, n, i;
    pbt_row_t rows [4] = '{
        '{A_CTRL, 16'h073E, 1'b1, 16'h073E}, '{A_CTRL, 16'h0000, 1'b1, 16'h0000},
        '{4'hF, 16'hFFFF, 1'b1, 16'h0000}, '{4'hE, 16'h0000, 1'b0, 16'h0000}};

    // Clock, 25 ns period
    always #12.5 clk = ~clk;

    pbt_core #(.DISC_CYC(20), .FILTER_CYC(10)) i_pbt_core (.clk(clk), .rst_b(rst_b),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bsy_in(bsy_in),
        .sel_in(sel_in), .rst_in(rst_in), .msg_in(msg_in), .cd_in(cd_in), .io_in(io_in),
        .db_in(db_in), .ack_in(ack_in), .req_in(req_in), .mode_ok(mode_ok),
        .phase_act(phase_act), .ready_in(ready_in), .bsy_oe(bsy_oe), .db_oe(db_oe),
        .atn_oe(atn_oe), .pcrca_oe(pcrca_oe), .req_ok(req_ok), .won(won),
        .mode_valid(mode_valid), .ready_out(ready_out));

    pbt_bus_model i_pbt_bus_model (.bsy_oe(bsy_oe), .db_oe(db_oe), .o_bsy(o_bsy),
        .o_sel(o_sel), .o_rst(o_rst), .o_phase(o_phase), .o_db(o_db), .bsy_in(bsy_in),
        .sel_in(sel_in), .rst_in(rst_in), .msg_in(msg_in), .cd_in(cd_in), .io_in(io_in),
        .db_in(db_in));

    // Compare and count
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Range test of a cycle count
    task in_range(input int x, input int lo, input int hi);
        chk({15'h0000, x >= lo && x <= hi}, 16'h0001);
    endtask

    // Settle past the edge before looking
    task tick;
        @(posedge clk);
        #1;
    endtask

    // One-cycle write strobe
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One-cycle read strobe, data in the following cycle
    task rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Count cycles until every drive is off
    task rel_check(input int hi);
        n = 0;
        while ({bsy_oe, db_oe, atn_oe, pcrca_oe} !== 11'h000 && n < 200) begin
            tick;
            n++;
        end
        in_range(n, 0, hi);
    endtask

    // Free the bus, arbitrate as ID 3, expect a win after lo cycles
    task arb_run(input logic [15:0] ctrl, input int lo);
        wr_reg(A_CTRL, ctrl);
        @(posedge clk);
        o_bsy <= 1'b0;
        n = 0;
        while (bsy_oe !== 1'b1 && n < 300) begin
            tick;
            n++;
        end
        in_range(n, SETTLE_CYC + FREE_CYC, SETTLE_CYC + SET_CYC + 2);
        chk({8'h00, db_oe}, 16'h0008);
        n = 0;
        while (won !== 1'b1 && n < 300) begin
            tick;
            n++;
        end
        in_range(n, lo, lo + 4);
    endtask

    // Verdict and end of run
    task wrap_up;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        // Outputs quiet under reset
        chk({1'b0, bsy_oe, db_oe, atn_oe, pcrca_oe, won, req_ok, mode_valid, ready_out}, 0);
        rst_b <= 1'b1;
        rd_reg(A_CTRL, v);
        chk(v, CTRL_RST);
        // Register rows, unmapped places read zero
        for (i = 0; i < 4; i++) begin
            if (rows[i].w) begin
                wr_reg(rows[i].a, rows[i].d);
            end
            rd_reg(rows[i].a, v);
            chk(v, rows[i].e);
        end
        // Control frozen while a phase is active
        @(posedge clk);
        phase_act <= 1'b1;
        wr_reg(A_CTRL, 16'h0118);
        rd_reg(A_CTRL, v);
        chk(v, 16'h0000);
        @(posedge clk);
        phase_act <= 1'b0;
        // Mode sense glitch shorter than the filter
        mode_ok <= 1'b1;
        repeat (5) tick;
        @(posedge clk);
        mode_ok <= 1'b0;
        repeat (8) tick;
        chk({15'h0000, mode_valid}, 16'h0000);
        @(posedge clk);
        mode_ok <= 1'b1;
        n = 0;
        while (mode_valid !== 1'b1 && n < 50) begin
            tick;
            n++;
        end
        in_range(n, 10, 13);
        // Readiness reported
        @(posedge clk);
        ready_in <= 1'b1;
        repeat (4) tick;
        chk({15'h0000, ready_out}, 16'h0001);
        // Plain arbitration, then I/O rises on an initiator
        arb_run(16'h0301, ARB_CYC);
        @(posedge clk);
        o_phase <= 3'h1;
        n = 0;
        while (db_oe !== 8'h00 && n < 100) begin
            tick;
            n++;
        end
        in_range(n, 0, DREL_CYC);
        @(posedge clk);
        o_rst <= 1'b1;
        rel_check(CLEAR_CYC);
        @(posedge clk);
        {o_rst, o_bsy, o_phase} <= 5'b01000;
        // Quick arbitration with MSG, C/D, I/O false
        arb_run(16'h0303, QAS_CYC);
        // Attention setup gates REQ, then a disconnect holds off arbitration
        wr_reg(A_CMD, 16'h0003);
        tick;
        chk({14'h0000, atn_oe, req_ok}, 16'h0002);
        n = 0;
        while (req_ok !== 1'b1 && n < 50) begin
            tick;
            n++;
        end
        in_range(n, ATN_CYC, ATN_CYC + 2);
        wr_reg(A_CMD, 16'h0004);
        tick;
        tick;
        n = 0;
        while (bsy_oe !== 1'b1 && n < 300) begin
            tick;
            n++;
        end
        in_range(n, 20 + FREE_CYC, 20 + FREE_CYC + 4);
        @(posedge clk);
        o_rst <= 1'b1;
        rel_check(CLEAR_CYC);
        @(posedge clk);
        {o_rst, o_bsy} <= 2'b01;
        // Higher rival ID, then rival SEL after the lost arbitration
        wr_reg(A_CTRL, 16'h0301);
        @(posedge clk);
        o_bsy <= 1'b0;
        n = 0;
        while (bsy_oe !== 1'b1 && n < 300) begin
            tick;
            n++;
        end
        @(posedge clk);
        {o_bsy, o_db} <= {1'b1, 8'h80};
        n = 0;
        repeat (ARB_CYC + 8) begin
            tick;
            if (won === 1'b1) n++;
        end
        chk(n[15:0], 16'h0000);
        @(posedge clk);
        o_sel <= 1'b1;
        rel_check(CLEAR_CYC);
        // Fresh arbitration, then I/O rises and a rival raises SEL
        @(posedge clk);
        {o_sel, o_bsy, o_db} <= {1'b0, 1'b0, 8'h00};
        n = 0;
        while (bsy_oe !== 1'b1 && n < 300) begin
            tick;
            n++;
        end
        @(posedge clk);
        o_phase <= 3'h1;
        n = 0;
        while (db_oe !== 8'h00 && n < 100) begin
            tick;
            n++;
        end
        in_range(n, 1, DREL_CYC);
        @(posedge clk);
        o_sel <= 1'b1;
        rel_check(CLEAR_CYC);
        chk({15'h0000, won}, 16'h0000);
        wrap_up();
    end
endmodule
